// ==== src/aia_acq.sv ====
// acquisition, encoding, modes and process events of the analog input block
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module aia_acq #(
   parameter int SCOPE_DEPTH = aia_pkg::SCOPE_DEPTH,
   parameter int FIFO_DEPTH  = aia_pkg::FIFO_DEPTH
)(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic [4:0]         addr,
   input  wire logic [31:0]        wr_data,
   input  wire logic               wr_en,
   input  wire logic               rd_en,
   output logic      [31:0]        rd_data,
   input  wire logic               adc_valid,
   input  wire logic [2:0]         adc_chan,
   input  wire logic signed [15:0] adc_raw,
   input  wire logic               supply_ok,
   output logic                    conv_start,
   output logic                    proc_irq,
   output logic      [31:0]        proc_irq_data,
   input  wire logic               proc_irq_ack,
   output logic                    diag
);
   localparam int SW = $clog2(SCOPE_DEPTH);
   localparam int FW = $clog2(FIFO_DEPTH);
   localparam int CH = aia_pkg::NUM_CH;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [17:0] aia_encode(input logic signed [15:0] raw,
                                              input logic perr);
      logic signed [21:0] prod;
      logic signed [17:0] s;
      logic        [17:0] r;
      prod = 22'(raw) * aia_pkg::SCALE_MUL;
      s = 18'(prod >>> aia_pkg::SCALE_SH);
      if (perr)
         r = {2'b00, aia_pkg::PERR_VAL};
      else if (s > aia_pkg::OVR_END)
         r = {2'b10, aia_pkg::CLAMP_HI};
      else if (s < aia_pkg::UND_END)
         r = {2'b01, aia_pkg::CLAMP_LO};
      else
         r = {2'b00, s[15:0]};
      return r;
   endfunction

   function automatic logic [FW-1:0] f_next(input logic [FW-1:0] p);
      return (p == FW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_sync_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [31:0]           ctrl;
   logic [15:0]           cycle_us;
   logic [31:0]           trig_cfg;
   logic [2:0]            fifo_sel;
   logic [31:0]           limit [CH];
   logic [15:0]           value [CH];
   aia_pkg::aia_mode_t    mode;
   logic                  mode_bad;
   logic [CH-1:0]         chan_perr;
   logic                  sc_start;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctrl <= aia_pkg::CTRL_RST; // RQ21
      end else if (wr_en && addr == aia_pkg::OFF_CTRL) begin
         ctrl <= wr_data;
         ctrl[aia_pkg::CTL_START] <= 1'b0;
         ctrl[aia_pkg::CTL_EOC] <= wr_data[aia_pkg::CTL_EOC]
                                   && cycle_us >= aia_pkg::EOC_MIN_US; // RQ8
      end else if (wr_en && addr == aia_pkg::OFF_CYCLE
                   && wr_data[15:0] < aia_pkg::EOC_MIN_US) begin
         ctrl[aia_pkg::CTL_EOC] <= 1'b0; // RQ8
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cycle_us <= aia_pkg::CYCLE_RST;
         trig_cfg <= aia_pkg::TRIG_RST;
         fifo_sel <= 3'h0;
      end else if (wr_en) begin
         if (addr == aia_pkg::OFF_CYCLE)
            cycle_us <= wr_data[15:0];
         if (addr == aia_pkg::OFF_TRIG)
            trig_cfg <= wr_data;
         if (addr == aia_pkg::OFF_FSEL)
            fifo_sel <= wr_data[2:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < CH; i++)
            limit[i] <= aia_pkg::LIMIT_RST;
      end else if (wr_en && addr[4:3] == aia_pkg::LIM_BANK) begin
         limit[addr[2:0]] <= wr_data;
      end
   end

   assign sc_start = wr_en && addr == aia_pkg::OFF_CTRL && wr_data[aia_pkg::CTL_START];

   // one mode at a time; code 3 is a parameter error
   always_comb begin
      mode_bad = 1'b0;
      case (ctrl[aia_pkg::CTL_MODE +: 2]) // RQ23
         2'h0:    mode = aia_pkg::MODE_STD;
         2'h1:    mode = aia_pkg::MODE_SCOPE;
         2'h2:    mode = aia_pkg::MODE_FIFO;
         default: begin
            mode     = aia_pkg::MODE_STD;
            mode_bad = 1'b1;
         end
      endcase
      for (int i = 0; i < CH; i++)
         chan_perr[i] = mode_bad
                        || $signed(limit[i][31:16]) < $signed(limit[i][15:0]);
   end

   // ------------------------------------------------------------
   // cycle timer
   // ------------------------------------------------------------
   logic [aia_pkg::TICK_W-1:0] us_cnt;
   logic                       us_tick;
   logic [15:0]                cyc_cnt;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         us_cnt  <= '0;
         us_tick <= 1'b0;
      end else if (us_cnt == aia_pkg::TICK_W'(aia_pkg::TICK_CYC - 1)) begin
         us_cnt  <= '0;
         us_tick <= 1'b1;
      end else begin
         us_cnt  <= us_cnt + 1'b1;
         us_tick <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cyc_cnt    <= 16'h0000;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (us_tick) begin
            if ({1'b0, cyc_cnt} + 17'h0_0001 >= {1'b0, cycle_us}) begin
               cyc_cnt    <= 16'h0000;
               conv_start <= 1'b1; // RQ7
            end else begin
               cyc_cnt <= cyc_cnt + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // sample encoding
   // ------------------------------------------------------------
   logic        s_valid;
   logic [2:0]  s_chan;
   logic [15:0] s_word;
   logic        s_ovr;
   logic        s_und;
   logic [15:0] old;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_valid <= 1'b0;
         s_chan  <= 3'h0;
         {s_ovr, s_und, s_word} <= 18'h0_0000;
      end else begin
         s_valid <= adc_valid;
         if (adc_valid) begin
            s_chan <= adc_chan;
            // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6
            {s_ovr, s_und, s_word} <= aia_encode(adc_raw, chan_perr[adc_chan]);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < CH; i++)
            value[i] <= 16'h0000;
      end else if (s_valid) begin
         value[s_chan] <= s_word; // RQ7
      end
   end

   assign old = value[s_chan];

   // ------------------------------------------------------------
   // process interrupts
   // ------------------------------------------------------------
   logic std_on;
   logic ev_hi;
   logic ev_lo;
   logic ev_eoc;
   logic lost_ev;

   assign std_on = mode == aia_pkg::MODE_STD && !mode_bad; // RQ12
   assign ev_hi  = s_valid && std_on && ctrl[aia_pkg::CTL_LIM] && !chan_perr[s_chan]
                   && $signed(old) <= $signed(limit[s_chan][31:16])
                   && $signed(s_word) > $signed(limit[s_chan][31:16]); // RQ10
   assign ev_lo  = s_valid && std_on && ctrl[aia_pkg::CTL_LIM] && !chan_perr[s_chan]
                   && $signed(old) >= $signed(limit[s_chan][15:0])
                   && $signed(s_word) < $signed(limit[s_chan][15:0]); // RQ10
   assign ev_eoc = s_valid && std_on && ctrl[aia_pkg::CTL_EOC]
                   && s_chan == 3'(CH - 1); // RQ9
   assign lost_ev = ((ev_hi || ev_lo || ev_eoc) && proc_irq && !proc_irq_ack)
                    || (ev_eoc && (ev_hi || ev_lo));

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         proc_irq      <= 1'b0;
         proc_irq_data <= 32'h0000_0000;
      end else if ((ev_hi || ev_lo || ev_eoc) && !(proc_irq && !proc_irq_ack)) begin
         proc_irq <= 1'b1;
         // RQ11
         proc_irq_data <= {ev_hi ? aia_pkg::IRQ_HI : ev_lo ? aia_pkg::IRQ_LO
                           : aia_pkg::IRQ_EOC, 5'h00, s_chan, s_word};
      end else if (proc_irq_ack) begin
         proc_irq <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // oscilloscope capture
   // ------------------------------------------------------------
   aia_pkg::aia_scope_t sc_st;
   logic [SW-1:0]       sc_wp;
   logic [SW-1:0]       sc_rp;
   logic [15:0]         scope_mem [SCOPE_DEPTH];
   logic                sc_on;
   logic                trig_hit;
   logic [15:0]         lvl;

   assign sc_on = mode == aia_pkg::MODE_SCOPE && !mode_bad;
   assign lvl   = trig_cfg[15:0];
   assign trig_hit = s_valid && s_chan == trig_cfg[aia_pkg::TRG_CHAN +: 3]
                     && (trig_cfg[aia_pkg::TRG_FALL]
                         ? ($signed(old) > $signed(lvl) && $signed(s_word) <= $signed(lvl))
                         : ($signed(old) < $signed(lvl) && $signed(s_word) >= $signed(lvl)));

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sc_st <= aia_pkg::SC_IDLE;
         sc_wp <= '0;
      end else if (!sc_on) begin
         sc_st <= aia_pkg::SC_IDLE;
         sc_wp <= '0;
      end else begin
         case (sc_st)
            aia_pkg::SC_IDLE, aia_pkg::SC_DONE: begin
               if (sc_start) begin
                  sc_st <= aia_pkg::SC_REC; // RQ15
                  sc_wp <= '0;
               end else if (sc_st == aia_pkg::SC_IDLE && ctrl[aia_pkg::CTL_AUTO]) begin
                  sc_st <= aia_pkg::SC_ARMED;
               end
            end
            aia_pkg::SC_ARMED: begin
               if (sc_start || trig_hit) begin
                  sc_st <= aia_pkg::SC_REC; // RQ15
                  sc_wp <= '0;
               end
            end
            aia_pkg::SC_REC: begin
               if (s_valid) begin
                  sc_wp <= sc_wp + 1'b1;
                  if (sc_wp == SW'(SCOPE_DEPTH - 1))
                     sc_st <= aia_pkg::SC_DONE; // RQ16
               end
            end
            default: sc_st <= aia_pkg::SC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sc_st == aia_pkg::SC_REC && s_valid)
         scope_mem[sc_wp] <= s_word; // RQ14
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         sc_rp <= '0;
      else if (sc_start || !sc_on)
         sc_rp <= '0;
      else if (rd_en && addr == aia_pkg::OFF_SDATA)
         sc_rp <= sc_rp + 1'b1;
   end

   // ------------------------------------------------------------
   // per-channel FIFO
   // ------------------------------------------------------------
   logic [FW-1:0] f_wp  [CH];
   logic [FW-1:0] f_rp  [CH];
   logic [FW-1:0] f_lvl [CH];
   logic [15:0]   fifo_mem [CH * (2 ** FW)];
   logic          fifo_on;
   logic          f_push;
   logic          f_pop;
   logic [CH-1:0] f_ovf_ev;

   assign fifo_on = mode == aia_pkg::MODE_FIFO && !mode_bad;
   assign f_push  = s_valid && fifo_on; // RQ17
   assign f_pop   = rd_en && addr == aia_pkg::OFF_FDATA && f_lvl[fifo_sel] != '0; // RQ18

   always_comb begin
      for (int i = 0; i < CH; i++)
         f_ovf_ev[i] = f_push && s_chan == 3'(i) && !(f_pop && fifo_sel == 3'(i))
                       && f_lvl[i] == FW'(FIFO_DEPTH); // RQ19
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < CH; i++) begin
            f_wp[i]  <= '0;
            f_rp[i]  <= '0;
            f_lvl[i] <= '0;
         end
      end else if (!fifo_on) begin
         for (int i = 0; i < CH; i++) begin
            f_wp[i]  <= '0;
            f_rp[i]  <= '0;
            f_lvl[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CH; i++) begin
            if (f_push && s_chan == 3'(i))
               f_wp[i] <= f_next(f_wp[i]); // RQ19
            if ((f_pop && fifo_sel == 3'(i)) || f_ovf_ev[i])
               f_rp[i] <= f_next(f_rp[i]);
            if (f_push && s_chan == 3'(i) && !(f_pop && fifo_sel == 3'(i))
                && f_lvl[i] != FW'(FIFO_DEPTH))
               f_lvl[i] <= f_lvl[i] + 1'b1;
            else if (f_pop && fifo_sel == 3'(i) && !(f_push && s_chan == 3'(i)))
               f_lvl[i] <= f_lvl[i] - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (f_push)
         fifo_mem[{s_chan, f_wp[s_chan]}] <= s_word; // RQ17
   end

   // ------------------------------------------------------------
   // status and diagnostics
   // ------------------------------------------------------------
   logic          irq_lost;
   logic          range_err;
   logic [CH-1:0] fifo_ovf;
   logic          st_clr;
   logic [31:0]   status;

   assign st_clr = wr_en && addr == aia_pkg::OFF_STATUS;

   // a set in the clearing cycle wins
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_lost  <= 1'b0;
         range_err <= 1'b0;
         fifo_ovf  <= '0;
      end else begin
         irq_lost  <= (irq_lost && !(st_clr && wr_data[aia_pkg::ST_LOST])) || lost_ev;
         range_err <= (range_err && !(st_clr && wr_data[aia_pkg::ST_RANGE]))
                      || (s_valid && (s_ovr || s_und));
         fifo_ovf  <= (fifo_ovf & ~(st_clr ? wr_data[aia_pkg::ST_FOVF +: CH] : '0))
                      | f_ovf_ev; // RQ19
      end
   end

   always_comb begin
      status = 32'h0000_0000;
      status[aia_pkg::ST_PERR]   = |chan_perr;
      status[aia_pkg::ST_LOST]   = irq_lost;
      status[aia_pkg::ST_RANGE]  = range_err;
      status[aia_pkg::ST_SUPPLY] = !supply_ok;
      status[aia_pkg::ST_SCDONE] = sc_st == aia_pkg::SC_DONE;
      status[aia_pkg::ST_SCREC]  = sc_st == aia_pkg::SC_REC;
      status[aia_pkg::ST_FOVF +: CH] = fifo_ovf;
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         diag <= 1'b0;
      else
         diag <= ctrl[aia_pkg::CTL_DIAG] // RQ13 RQ21
                 && (|chan_perr || irq_lost || range_err || !supply_ok);
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_data <= 32'h0000_0000;
      end else if (!rd_en) begin
         rd_data <= 32'h0000_0000;
      end else if (addr[4:3] == aia_pkg::VAL_BANK) begin
         rd_data <= {16'h0000, value[addr[2:0]]};
      end else if (addr[4:3] == aia_pkg::LIM_BANK) begin
         rd_data <= limit[addr[2:0]];
      end else begin
         case (addr)
            aia_pkg::OFF_CTRL:   rd_data <= ctrl;
            aia_pkg::OFF_CYCLE:  rd_data <= {16'h0000, cycle_us};
            aia_pkg::OFF_STATUS: rd_data <= status;
            aia_pkg::OFF_TRIG:   rd_data <= trig_cfg;
            aia_pkg::OFF_FSEL:   rd_data <= {29'h0000_0000, fifo_sel};
            aia_pkg::OFF_FDATA:  rd_data <= f_pop
                                 ? {16'h0000, fifo_mem[{fifo_sel, f_rp[fifo_sel]}]}
                                 : 32'h0000_0000; // RQ18
            aia_pkg::OFF_FLVL:   rd_data <= 32'(f_lvl[fifo_sel]);
            aia_pkg::OFF_SDATA:  rd_data <= {16'h0000, scope_mem[sc_rp]};
            aia_pkg::OFF_SCNT:   rd_data <= {14'h0000, sc_st, 16'(sc_wp)};
            default:             rd_data <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// ==== src/aia_pkg.sv ====
// constants and types of the analog input acquisition block
// How it works
// RQ1: values leave as signed 16-bit words
// RQ2: above overdrive end output 7FFFh
// RQ3: below underdrive end output 8000h
// RQ4: bad channel parameters output 32767
// RQ5: ten volt full scale maps to 27648
// RQ6: twenty milliamp scale, half scale 3600h
// RQ7: standard mode samples all eight channels cyclically
// RQ8: end-of-cycle interrupt needs cycle of 200us
// RQ9: end-of-cycle interrupt after last channel converts
// RQ10: limit crossing raises a process interrupt
// RQ11: every process interrupt carries four data bytes
// RQ12: no process interrupts in scope or FIFO
// RQ13: diagnostics for parameters, lost interrupt, range, supply
// RQ14: scope buffer holds 65536 samples
// RQ15: scope starts manually or on signal edge
// RQ16: scope recording stops when buffer full
// RQ17: FIFO holds 8190 values per channel
// RQ18: controller reads FIFO in packets
// RQ19: FIFO overflow wraps, overwrites and flags error
// RQ20: controller places modules on 256-byte slots
// RQ21: diagnostics disabled after power-up
// RQ22: controller sends parameters on entering run
// RQ23: exactly one of three modes active; mode code 3 leaves none active and flags a parameter error
package aia_pkg;
   // ------------------------------------------------------------
   // sizes and timing
   // ------------------------------------------------------------
   localparam int NUM_CH      = 8;
   localparam int SCOPE_DEPTH = 65536;
   localparam int FIFO_DEPTH  = 8190;
   localparam int CLK_HZ      = 20_000_000;
   localparam int US_PER_S    = 1_000_000;
   localparam int TICK_CYC    = CLK_HZ / US_PER_S;
   localparam int TICK_W      = $clog2(TICK_CYC);
   localparam logic [15:0] EOC_MIN_US = 16'h00c8;
   localparam logic [15:0] CYCLE_RST  = 16'h00c8;
   // ------------------------------------------------------------
   // register offsets (word index)
   // ------------------------------------------------------------
   localparam logic [4:0] OFF_CTRL   = 5'h00;
   localparam logic [4:0] OFF_CYCLE  = 5'h01;
   localparam logic [4:0] OFF_STATUS = 5'h02;
   localparam logic [4:0] OFF_TRIG   = 5'h03;
   localparam logic [4:0] OFF_FSEL   = 5'h04;
   localparam logic [4:0] OFF_FDATA  = 5'h05;
   localparam logic [4:0] OFF_FLVL   = 5'h06;
   localparam logic [4:0] OFF_SDATA  = 5'h07;
   localparam logic [4:0] OFF_SCNT   = 5'h18;
   localparam logic [1:0] VAL_BANK   = 2'h1;
   localparam logic [1:0] LIM_BANK   = 2'h2;
   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   localparam int CTL_MODE  = 0;
   localparam int CTL_EOC   = 2;
   localparam int CTL_LIM   = 3;
   localparam int CTL_DIAG  = 4;
   localparam int CTL_START = 5;
   localparam int CTL_AUTO  = 6;
   localparam int TRG_CHAN  = 16;
   localparam int TRG_FALL  = 19;
   localparam int ST_PERR   = 0;
   localparam int ST_LOST   = 1;
   localparam int ST_RANGE  = 2;
   localparam int ST_SUPPLY = 3;
   localparam int ST_SCDONE = 4;
   localparam int ST_SCREC  = 5;
   localparam int ST_FOVF   = 8;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] TRIG_RST  = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST = 32'h7fff_8000;
   // ------------------------------------------------------------
   // encoding: raw full scale 4000h times 27/16 gives 6C00h
   // ------------------------------------------------------------
   localparam logic signed [21:0] SCALE_MUL = 22'sh00_001b;
   localparam int SCALE_SH = 4;
   localparam logic signed [17:0] OVR_END = 18'sh0_7eff;
   localparam logic signed [17:0] UND_END = 18'sh3_8100;
   localparam logic [15:0] CLAMP_HI = 16'h7fff;
   localparam logic [15:0] CLAMP_LO = 16'h8000;
   localparam logic [15:0] PERR_VAL = 16'h7fff;
   localparam logic [7:0]  IRQ_HI   = 8'h01;
   localparam logic [7:0]  IRQ_LO   = 8'h02;
   localparam logic [7:0]  IRQ_EOC  = 8'h04;
   typedef enum logic [1:0] {MODE_STD, MODE_SCOPE, MODE_FIFO} aia_mode_t;
   typedef enum logic [1:0] {SC_IDLE, SC_ARMED, SC_REC, SC_DONE} aia_scope_t;
endpackage

// ==== test/aia_acq_assertions.sv ====
// port assertions of the acquisition block
`timescale 1ns/10ps
module aia_acq_chk (
   input wire logic               sys_clk,
   input wire logic               rst_n,
   input wire logic               adc_valid,
   input wire logic [2:0]         adc_chan,
   input wire logic signed [15:0] adc_raw,
   input wire logic               conv_start,
   input wire logic               proc_irq,
   input wire logic [31:0]        proc_irq_data,
   input wire logic               proc_irq_ack,
   input wire logic               diag
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_conv_one_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   a_irq_from_sample: assert property ($rose(proc_irq) |-> $past(adc_valid, 2))
      else $error("interrupt without a sample two cycles before");
   a_cycle_end_last: assert property ($rose(proc_irq) && proc_irq_data[31:24] == 8'h04
      |-> proc_irq_data[18:16] == 3'h7 && $past(adc_chan, 2) == 3'h7)
      else $error("end of cycle not on the last channel");
   a_irq_held: assert property (proc_irq && !proc_irq_ack
      |=> proc_irq && $stable(proc_irq_data))
      else $error("pending interrupt changed before ack");
   a_irq_acked: assert property (proc_irq && proc_irq_ack && !$past(adc_valid) |=> !proc_irq)
      else $error("interrupt not cleared by ack");
   a_diag_boot_off: assert property ($rose(rst_n) |-> !diag ##1 !diag)
      else $error("diagnostic active after reset");
   a_clamp_no_gap: assert property ($rose(proc_irq) |-> !(proc_irq_data[15:0]
      inside {[16'h7f00:16'h7ffe], [16'h8001:16'h80ff]}))
      else $error("value between range end and clamp");
   a_sign_follows: assert property ($rose(proc_irq) |-> proc_irq_data[15:0] == 16'h7fff
      || proc_irq_data[15] == $past(adc_raw[15], 2))
      else $error("sign bit differs from sample");
endmodule
bind aia_acq aia_acq_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .adc_valid(adc_valid),
   .adc_chan(adc_chan), .adc_raw(adc_raw), .conv_start(conv_start), .proc_irq(proc_irq),
   .proc_irq_data(proc_irq_data), .proc_irq_ack(proc_irq_ack), .diag(diag));

// ==== test/aia_adc_model.sv ====
// converter model: one sample per channel after each conversion start that arrives while run is high and the model is idle
`timescale 1ns/10ps
module aia_adc_model (
   input  wire logic               sys_clk,
   input  wire logic               run,
   input  wire logic               conv_start,
   input  wire logic signed [15:0] level,
   output logic                    adc_valid = 1'b0,
   output logic [2:0]              adc_chan = 3'h0,
   output logic signed [15:0]      adc_raw = 16'h0
);
   logic [3:0] left = 4'h0;
   always @(posedge sys_clk) begin
      if (conv_start && run && left == 4'h0) begin
         left <= 4'h8;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
      adc_valid <= left != 4'h0;
      adc_chan  <= 3'(4'h8 - left);
      // idle data toggles so a stale sample is never mistaken for fresh
      adc_raw   <= (left != 4'h0) ? level : ~adc_raw;
   end
endmodule

// ==== test/tb.sv ====
// self-checking bench of the analog input acquisition block
`timescale 1ns/10ps
module tb;
   logic sys_clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, supply_ok = 1, proc_irq_ack = 0;
   logic [4:0] addr = 0;
   logic [31:0] wr_data = 0, rd_data, proc_irq_data, d;
   logic adc_valid, conv_start, proc_irq, diag, run = 1;
   logic [2:0] adc_chan;
   logic signed [15:0] adc_raw, level = 0;
   int err_total = 0, cmp_count = 0, cyc = 0;
   always #25 sys_clk = ~sys_clk;
   aia_acq #(.SCOPE_DEPTH(64), .FIFO_DEPTH(6)) aia_acq_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_raw(adc_raw), .supply_ok(supply_ok),
      .conv_start(conv_start), .proc_irq(proc_irq), .proc_irq_data(proc_irq_data),
      .proc_irq_ack(proc_irq_ack), .diag(diag));
   aia_adc_model aia_adc_model_i (.sys_clk(sys_clk), .run(run), .conv_start(conv_start),
      .level(level), .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_raw(adc_raw));
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic irq_take(input logic [31:0] exp);
      int n = 0;
      while (proc_irq !== 1'b1 && n < 9000) begin
         step(1);
         n++;
      end
      chk(proc_irq_data, exp);
      proc_irq_ack <= 1'b1;
      step(1);
      proc_irq_ack <= 1'b0;
      chk({31'h0, proc_irq}, 32'h0);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic t_encode;
      logic [15:0] raw [5] = '{16'h4000, 16'h2000, 16'hc000, 16'h7fff, 16'h8000};
      logic [15:0] enc [5] = '{16'h6c00, 16'h3600, 16'h9400, 16'h7fff, 16'h8000};
      chk({31'h0, diag}, 32'h0);
      rd(5'h19);
      chk(d, 32'h0);
      wr(aia_pkg::OFF_CYCLE, 32'h2);
      for (int i = 0; i < 5; i++) begin
         level <= raw[i];
         step(100);
         for (int c = 0; c < 8; c++) begin
            rd({aia_pkg::VAL_BANK, 3'(c)});
            chk({16'h0, d[15:0]}, {16'h0, enc[i]});
         end
      end
      wr(aia_pkg::OFF_CTRL, 32'h3);
      step(100);
      rd({aia_pkg::VAL_BANK, 3'h2});
      chk({16'h0, d[15:0]}, 32'h7fff);
      $display("encode test done");
   endtask
   task automatic t_limit;
      wr(aia_pkg::OFF_CTRL, 32'h0);
      level <= 16'sh0;
      wr({aia_pkg::LIM_BANK, 3'h0}, 32'h1000_f000);
      step(100);
      wr(aia_pkg::OFF_CTRL, 32'h8);
      level <= 16'sh4000;
      irq_take(32'h0100_6c00);
      level <= 16'shc000;
      irq_take(32'h0200_9400);
      wr(aia_pkg::OFF_CTRL, 32'h9);
      level <= 16'sh4000;
      step(100);
      chk({31'h0, proc_irq}, 32'h0);
      $display("limit test done");
   endtask
   task automatic t_fifo;
      wr(aia_pkg::OFF_FSEL, 32'h0);
      wr(aia_pkg::OFF_CTRL, 32'h2);
      step(400);
      run <= 1'b0;
      step(60);
      rd(aia_pkg::OFF_FLVL);
      chk(d, 32'h6);
      rd(aia_pkg::OFF_STATUS);
      chk({31'h0, d[aia_pkg::ST_FOVF]}, 32'h1);
      rd(aia_pkg::OFF_FDATA);
      chk({16'h0, d[15:0]}, 32'h6c00);
      rd(aia_pkg::OFF_FLVL);
      chk(d, 32'h5);
      run <= 1'b1;
      $display("fifo test done");
   endtask
   task automatic t_scope;
      wr(aia_pkg::OFF_CTRL, 32'h1);
      wr(aia_pkg::OFF_CTRL, 32'h21);
      step(500);
      rd(aia_pkg::OFF_SCNT);
      chk({30'h0, d[17:16]}, 32'h3);
      rd(aia_pkg::OFF_SDATA);
      chk({16'h0, d[15:0]}, 32'h6c00);
      wr(aia_pkg::OFF_CTRL, 32'h0);
      wr(aia_pkg::OFF_TRIG, 32'h1000);
      level <= 16'sh0;
      wr(aia_pkg::OFF_CTRL, 32'h41);
      step(100);
      rd(aia_pkg::OFF_SCNT);
      chk({30'h0, d[17:16]}, 32'h1);
      level <= 16'sh4000;
      step(100);
      rd(aia_pkg::OFF_SCNT);
      chk({30'h0, d[17:16]}, 32'h2);
      $display("scope test done");
   endtask
   task automatic t_diag;
      wr(aia_pkg::OFF_CTRL, 32'h10);
      wr(aia_pkg::OFF_STATUS, 32'hff06);
      supply_ok <= 1'b0;
      step(5);
      chk({31'h0, diag}, 32'h1);
      supply_ok <= 1'b1;
      step(5);
      chk({31'h0, diag}, 32'h0);
      $display("diag test done");
   endtask
   task automatic t_eoc;
      wr(aia_pkg::OFF_CYCLE, 32'h64);
      wr(aia_pkg::OFF_CTRL, 32'h4);
      rd(aia_pkg::OFF_CTRL);
      chk(d, 32'h0);
      wr(aia_pkg::OFF_CYCLE, 32'hc8);
      wr(aia_pkg::OFF_CTRL, 32'h4);
      rd(aia_pkg::OFF_CTRL);
      chk(d, 32'h4);
      irq_take(32'h0407_6c00);
      $display("cycle end test done");
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      step(20);
      rst_n <= 1'b1;
      step(3);
      t_encode;
      t_limit;
      t_fifo;
      t_scope;
      t_diag;
      t_eoc;
      close_out;
   end
endmodule
